// File: hw/capture_unit.sv
// Purpose: edge detector and prescaler for the capture input pin
// Assumes: pin already passed two flip-flops
// Notes:   counter restarts when the mode changes
`timescale 1ns/1ns
`default_nettype none
module capture_unit
  import timer16_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         pin_sync,
  input  wire logic [3:0]   capture_mode_field,
  input  wire logic [15:0]  timer_value,
  output capture_evt_t      evt
);

  logic       pin_prev_r;
  logic [3:0] edge_cnt_r;
  logic [3:0] mode_prev_r;
  logic       rise;
  logic       fall;
  logic       hit;

  assign rise = pin_sync & ~pin_prev_r;
  assign fall = ~pin_sync & pin_prev_r;

  // the pin level is watched whatever drives it, so a port write counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_r <= CAPT_OFF;
      edge_cnt_r  <= 4'h0;
    end else begin
      mode_prev_r <= capture_mode_field;
      if (capture_mode_field != mode_prev_r) begin
        edge_cnt_r <= 4'h0;
      end else if (rise) begin
        edge_cnt_r <= edge_cnt_r + 4'h1;
      end
    end
  end

  always_comb begin
    hit = 1'b0;
    case (capture_mode_field)
      CAPT_FALL:   hit = fall;
      CAPT_RISE:   hit = rise;
      CAPT_RISE4:  hit = rise && (edge_cnt_r[1:0] == RISE4_LAST[1:0]);
      CAPT_RISE16: hit = rise && (edge_cnt_r == RISE16_LAST);
      default:     hit = 1'b0;
    endcase
  end

  // the selected timer value is sampled in the event cycle itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;
    end else begin
      evt.fire  <= hit;
      evt.value <= timer_value;
    end
  end

endmodule
`default_nettype wire

// File: hw/timer16.sv
// Purpose: 16-bit timer/counter with control register and input capture
// Assumes: one clock pclk at 25 MHz, APB slave for software access
// Notes:   external clock and capture pin are asynchronous pins
`timescale 1ns/1ns
`default_nettype none

module timer16
  import timer16_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_clk_en,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        special_event_trigger,
  input  wire logic        sysclk_from_timer_osc,
  input  wire logic [15:0] second_timer_value,
  output logic             timer_osc_power,
  output logic             timer_overflow_flag,
  output logic             capture_event_flag,
  output logic             capture_to_second
);

  timer_ctrl_t  ctrl_r;
  logic [15:0]  count_r;
  logic [15:0]  capture_r;
  logic [3:0]   capture_mode_r;
  logic [7:0]   high_buf_r;
  logic [7:0]   wr_high_buf_r;
  logic         sel_second_r;
  logic         ovf_flag_r;
  logic         capt_flag_r;
  logic [2:0]   presc_cnt_r;
  logic [1:0]   ext_sync_r;
  logic         ext_prev_sync_r;
  logic         ext_prev_raw_r;
  logic [1:0]   capt_pin_r;
  logic [1:0]   sysclk_r;
  logic [31:0]  rdata_nxt;
  logic         wr_en;
  logic         rd_en;
  logic         mapped;
  logic         count_wr;
  logic         src_tick;
  logic         presc_tick;
  logic         count_tick;
  logic [2:0]   presc_last;
  logic [15:0]  capt_src;
  capture_evt_t evt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // a software load of the count beats the tick, so no rollover happens then
  assign count_wr = wr_en && (paddr == OFF_COUNT_LOW
                    || (paddr == OFF_COUNT_HIGH && !ctrl_r.wide_access_mode));

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      OFF_CONTROL, OFF_COUNT_LOW, OFF_COUNT_HIGH, OFF_CAPT_LOW,
      OFF_CAPT_HIGH, OFF_CAPT_CTRL, OFF_FLAGS, OFF_SECOND_CTRL:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // pins from outside the clock domain pass two flip-flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_r      <= 2'b00;
      ext_prev_sync_r <= 1'b0;
      ext_prev_raw_r  <= 1'b0;
      capt_pin_r      <= 2'b00;
      sysclk_r        <= 2'b00;
    end else begin
      ext_sync_r      <= {ext_sync_r[0], ext_count_clock_pin};
      ext_prev_sync_r <= ext_sync_r[1];
      ext_prev_raw_r  <= ext_sync_r[1];
      capt_pin_r      <= {capt_pin_r[0], capture_input_pin};
      sysclk_r        <= {sysclk_r[0], sysclk_from_timer_osc};
    end
  end

  // with one clock the unsynchronised path still needs the two flip-flops,
  // so both settings share one edge detector and the same latency
  always_comb begin
    if (!ctrl_r.clock_source_sel) begin
      src_tick = instr_clk_en;
    end else if (ctrl_r.ext_clock_nosync) begin
      src_tick = ext_sync_r[1] & ~ext_prev_raw_r;
    end else begin
      src_tick = ext_sync_r[1] & ~ext_prev_sync_r;
    end
  end

  always_comb begin
    case (ctrl_r.input_prescale_sel)
      2'b00:   presc_last = 3'h0;
      2'b01:   presc_last = 3'h1;
      2'b10:   presc_last = 3'h3;
      default: presc_last = 3'h7;
    endcase
  end

  assign presc_tick = src_tick && (presc_cnt_r >= presc_last);
  assign count_tick = presc_tick && ctrl_r.timer_run_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= PRESC_CNT_RESET;
    end else if (!ctrl_r.timer_run_bit) begin
      presc_cnt_r <= PRESC_CNT_RESET;
    end else if (presc_tick) begin
      presc_cnt_r <= PRESC_CNT_RESET;
    end else if (src_tick) begin
      presc_cnt_r <= presc_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= timer_ctrl_t'(CONTROL_RESET[6:0]);
    end else if (wr_en && paddr == OFF_CONTROL) begin
      ctrl_r.wide_access_mode   <= pwdata[BIT_WIDE];
      ctrl_r.input_prescale_sel <= pwdata[BIT_PRESC_LO +: 2];
      ctrl_r.timer_osc_enable   <= pwdata[BIT_OSC_EN];
      ctrl_r.ext_clock_nosync   <= pwdata[BIT_NOSYNC];
      ctrl_r.clock_source_sel   <= pwdata[BIT_CLK_SRC];
      ctrl_r.timer_run_bit      <= pwdata[BIT_RUN];
    end
  end

  // count: trigger reset, then software writes, then counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= COUNT_RESET;
    end else if (special_event_trigger) begin
      count_r <= COUNT_RESET;
    end else if (wr_en && paddr == OFF_COUNT_LOW) begin
      if (ctrl_r.wide_access_mode) begin
        count_r <= {wr_high_buf_r, pwdata[7:0]};
      end else begin
        count_r[7:0] <= pwdata[7:0];
      end
    end else if (wr_en && paddr == OFF_COUNT_HIGH
                 && !ctrl_r.wide_access_mode) begin
      count_r[15:8] <= pwdata[7:0];
    end else if (count_tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // wide mode: high byte written to a buffer, low-byte read latches high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_high_buf_r <= 8'h00;
      high_buf_r    <= 8'h00;
    end else begin
      if (wr_en && paddr == OFF_COUNT_HIGH && ctrl_r.wide_access_mode) begin
        wr_high_buf_r <= pwdata[7:0];
      end
      if (rd_en && paddr == OFF_COUNT_LOW) begin
        high_buf_r <= count_r[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_mode_r <= CAPT_OFF;
      sel_second_r   <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_CAPT_CTRL) begin
        capture_mode_r <= pwdata[3:0];
      end
      if (wr_en && paddr == OFF_SECOND_CTRL) begin
        sel_second_r <= pwdata[BIT_SEL_SECOND];
      end
    end
  end

  assign capt_src = sel_second_r ? second_timer_value : count_r;

  capture_unit u_capture (
    .pclk               (pclk),
    .presetn            (presetn),
    .pin_sync           (capt_pin_r[1]),
    .capture_mode_field (capture_mode_r),
    .timer_value        (capt_src),
    .evt                (evt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_r <= COUNT_RESET;
    end else if (evt.fire) begin
      capture_r <= evt.value;
    end
  end

  // flags: write one to clear, but a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_r  <= 1'b0;
      capt_flag_r <= 1'b0;
    end else begin
      if (count_tick && count_r == 16'hFFFF && !special_event_trigger
          && !count_wr) begin
        ovf_flag_r <= 1'b1;
      end else if (wr_en && paddr == OFF_FLAGS && pwdata[BIT_FLAG_OVF]) begin
        ovf_flag_r <= 1'b0;
      end
      if (evt.fire) begin
        capt_flag_r <= 1'b1;
      end else if (wr_en && paddr == OFF_FLAGS && pwdata[BIT_FLAG_CAPT]) begin
        capt_flag_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      OFF_CONTROL: begin
        rdata_nxt[BIT_WIDE]             = ctrl_r.wide_access_mode;
        rdata_nxt[BIT_SYSCLK]           = sysclk_r[1];
        rdata_nxt[BIT_PRESC_LO +: 2]    = ctrl_r.input_prescale_sel;
        rdata_nxt[BIT_OSC_EN]           = ctrl_r.timer_osc_enable;
        rdata_nxt[BIT_NOSYNC]           = ctrl_r.ext_clock_nosync;
        rdata_nxt[BIT_CLK_SRC]          = ctrl_r.clock_source_sel;
        rdata_nxt[BIT_RUN]              = ctrl_r.timer_run_bit;
      end
      OFF_COUNT_LOW:   rdata_nxt[15:0] = ctrl_r.wide_access_mode
                                         ? {8'h00, count_r[7:0]}
                                         : {8'h00, count_r[7:0]};
      OFF_COUNT_HIGH:  rdata_nxt[7:0]  = ctrl_r.wide_access_mode
                                         ? high_buf_r : count_r[15:8];
      OFF_CAPT_LOW:    rdata_nxt[7:0]  = capture_r[7:0];
      OFF_CAPT_HIGH:   rdata_nxt[7:0]  = capture_r[15:8];
      OFF_CAPT_CTRL:   rdata_nxt[3:0]  = capture_mode_r;
      OFF_FLAGS: begin
        rdata_nxt[BIT_FLAG_OVF]  = ovf_flag_r;
        rdata_nxt[BIT_FLAG_CAPT] = capt_flag_r;
      end
      OFF_SECOND_CTRL: rdata_nxt[BIT_SEL_SECOND] = sel_second_r;
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  // no wait state: pready rises in the first access cycle, from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_osc_power     <= 1'b0;
      timer_overflow_flag <= 1'b0;
      capture_event_flag  <= 1'b0;
      capture_to_second   <= 1'b0;
    end else begin
      timer_osc_power     <= ctrl_r.timer_osc_enable;
      timer_overflow_flag <= ovf_flag_r;
      capture_event_flag  <= capt_flag_r;
      capture_to_second   <= sel_second_r;
    end
  end

endmodule
`default_nettype wire

// File: hw/timer16_pkg.sv
// Purpose: shared constants and carriers for the 16-bit timer with capture
// Assumes: 32-bit APB, each register one aligned word
// Notes:   offsets are byte addresses
package timer16_pkg;

  localparam logic [11:0] OFF_CONTROL     = 12'h000;
  localparam logic [11:0] OFF_COUNT_LOW   = 12'h004;
  localparam logic [11:0] OFF_COUNT_HIGH  = 12'h008;
  localparam logic [11:0] OFF_CAPT_LOW    = 12'h00C;
  localparam logic [11:0] OFF_CAPT_HIGH   = 12'h010;
  localparam logic [11:0] OFF_CAPT_CTRL   = 12'h014;
  localparam logic [11:0] OFF_FLAGS       = 12'h018;
  localparam logic [11:0] OFF_SECOND_CTRL = 12'h01C;

  localparam int BIT_RUN      = 0;
  localparam int BIT_CLK_SRC  = 1;
  localparam int BIT_NOSYNC   = 2;
  localparam int BIT_OSC_EN   = 3;
  localparam int BIT_PRESC_LO = 4;
  localparam int BIT_SYSCLK   = 6;
  localparam int BIT_WIDE     = 7;

  localparam int BIT_FLAG_OVF  = 0;
  localparam int BIT_FLAG_CAPT = 1;

  localparam int BIT_SEL_SECOND = 0;

  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [2:0]  PRESC_CNT_RESET = 3'h0;

  // capture mode field codes
  localparam logic [3:0] CAPT_OFF    = 4'h0;
  localparam logic [3:0] CAPT_FALL   = 4'h4;
  localparam logic [3:0] CAPT_RISE   = 4'h5;
  localparam logic [3:0] CAPT_RISE4  = 4'h6;
  localparam logic [3:0] CAPT_RISE16 = 4'h7;

  localparam logic [3:0] RISE4_LAST  = 4'h3;
  localparam logic [3:0] RISE16_LAST = 4'hF;

  typedef struct packed {
    logic       wide_access_mode;
    logic [1:0] input_prescale_sel;
    logic       timer_osc_enable;
    logic       ext_clock_nosync;
    logic       clock_source_sel;
    logic       timer_run_bit;
  } timer_ctrl_t;

  typedef struct packed {
    logic        fire;
    logic [15:0] value;
  } capture_evt_t;

endpackage

// File: testbench/pin_model.sv
// Purpose: external count clock source and capture signal driver
// Assumes: pulses slow enough for the two-flop synchronisers
// Notes:   pins rest low between pulses
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input  wire logic pclk,
  output logic      ext_count_clock_pin,
  output logic      capture_input_pin
);
  initial begin
    ext_count_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end

  // which 0 drives the count clock, 1 the capture pin
  task automatic pulse(input logic which, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (which) capture_input_pin <= 1'b1;
      else ext_count_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      if (which) capture_input_pin <= 1'b0;
      else ext_count_clock_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/timer16_chk.sv
// Purpose: port-level checks of the timer16 bus and flags
// Assumes: one clock pclk, presetn asynchronous active low
// Notes:   flags may only fall, and oscillator power only change, after a write
`timescale 1ns/1ns
`default_nettype none
module timer16_chk
  import timer16_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_osc_power,
  input wire logic        timer_overflow_flag,
  input wire logic        capture_event_flag
);
  logic [3:0] flag_wr_r;
  logic [3:0] ctrl_wr_r;
  wire logic  wr_w = psel && penable && pready && pwrite;

  // short history so a late flag copy still sees its clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_wr_r <= 4'h0;
    end else begin
      flag_wr_r <= {flag_wr_r[2:0], wr_w && paddr == OFF_FLAGS};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_wr_r <= 4'h0;
    end else begin
      ctrl_wr_r <= {ctrl_wr_r[2:0], wr_w && paddr == OFF_CONTROL};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence

  property p_answer;
    s_setup |=> s_done;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_idle_data;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("read data outside answer");
  property p_decode;
    s_done and (paddr[1:0] == 2'h0 && paddr <= OFF_SECOND_CTRL)
      |-> !pslverr;
  endproperty
  a_decode: assert property (p_decode)
    else $error("error on mapped address");
  property p_err_qual;
    pslverr |-> s_done;
  endproperty
  a_err_qual: assert property (p_err_qual)
    else $error("error outside answer");
  property p_ovf_hold;
    $fell(timer_overflow_flag) |-> flag_wr_r != 4'h0;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped by itself");
  property p_capt_hold;
    $fell(capture_event_flag) |-> flag_wr_r != 4'h0;
  endproperty
  a_capt_hold: assert property (p_capt_hold)
    else $error("capture flag dropped by itself");
  property p_osc_power;
    $changed(timer_osc_power) |-> ctrl_wr_r != 4'h0;
  endproperty
  a_osc_power: assert property (p_osc_power)
    else $error("oscillator power moved without write");
endmodule

bind timer16 timer16_chk chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .timer_osc_power,
  .timer_overflow_flag, .capture_event_flag);
`default_nettype wire

// File: testbench/timer16_with_input_capture_tb.sv
// Purpose: self-checking bench for timer16
// Assumes: APB master here, pins from pin_model
// Notes:   reads queue their expected answer for the monitor
`timescale 1ns/1ns
`default_nettype none
module timer16_with_input_capture_tb
  import timer16_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, instr_clk_en = 1'b0, special_event_trigger = 1'b0;
  logic sysclk_from_timer_osc = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] second_timer_value = 16'h0;
  logic pready, pslverr, ext_count_clock_pin, capture_input_pin;
  logic timer_osc_power, timer_overflow_flag, capture_event_flag;
  logic capture_to_second;
  logic [32:0] exp_q[$];
  int n_fail = 0, n_checks = 0;

  always #20 pclk = ~pclk;

  timer16 dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .instr_clk_en,
    .ext_count_clock_pin, .capture_input_pin, .special_event_trigger,
    .sysclk_from_timer_osc, .second_timer_value, .timer_osc_power,
    .timer_overflow_flag, .capture_event_flag, .capture_to_second);
  pin_model pm_u (.pclk, .ext_count_clock_pin, .capture_input_pin);

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      instr_clk_en <= 1'b1;
      @(posedge pclk);
      instr_clk_en <= 1'b0;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // every read answer is compared with the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(33'h1, 33'h0);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h0852));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CONTROL, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    wr(12'h024, 32'hFF);
    sysclk_from_timer_osc <= 1'b1;
    wr(OFF_CONTROL, 32'h08);
    idle(4);
    rd(OFF_CONTROL, 32'h48, 1'b0);
    check({32'h0, timer_osc_power}, 33'h1);
    sysclk_from_timer_osc <= 1'b0;
    wr(OFF_CONTROL, 32'h40);
    idle(4);
    rd(OFF_CONTROL, 32'h0, 1'b0);
    check({32'h0, timer_osc_power}, 33'h0);
    for (int p = 0; p < 4; p++) begin
      wr(OFF_COUNT_LOW, 32'h0);
      wr(OFF_CONTROL, 32'(8'h01 + (p << 4)));
      tick(16);
      wr(OFF_CONTROL, 32'(p << 4));
      tick(8);
      rd(OFF_COUNT_LOW, 32'(16 >> p), 1'b0);
    end
    wr(OFF_COUNT_HIGH, 32'hFF);
    wr(OFF_COUNT_LOW, 32'hFF);
    wr(OFF_CONTROL, 32'h01);
    tick(1);
    idle(3);
    check({32'h0, timer_overflow_flag}, 33'h1);
    rd(OFF_COUNT_HIGH, 32'h0, 1'b0);
    rd(OFF_FLAGS, 32'h1, 1'b0);
    wr(OFF_FLAGS, 32'h1);
    idle(3);
    check({32'h0, timer_overflow_flag}, 33'h0);
    tick(5);
    @(posedge pclk);
    special_event_trigger <= 1'b1;
    @(posedge pclk);
    special_event_trigger <= 1'b0;
    rd(OFF_COUNT_LOW, 32'h0, 1'b0);
    // wide mode buffers the high byte until the low byte is written
    wr(OFF_CONTROL, 32'h80);
    wr(OFF_COUNT_HIGH, 32'h12);
    wr(OFF_COUNT_LOW, 32'h34);
    rd(OFF_COUNT_LOW, 32'h34, 1'b0);
    rd(OFF_COUNT_HIGH, 32'h12, 1'b0);
    wr(OFF_COUNT_HIGH, 32'h56);
    wr(OFF_CONTROL, 32'h00);
    rd(OFF_COUNT_HIGH, 32'h12, 1'b0);
    wr(OFF_COUNT_HIGH, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_COUNT_LOW, 32'h0);
      wr(OFF_CONTROL, 32'(8'h03 + (s << 2)));
      pm_u.pulse(1'b0, 5);
      idle(6);
      rd(OFF_COUNT_LOW, 32'h5, 1'b0);
    end
    wr(OFF_CONTROL, 32'h05);
    pm_u.pulse(1'b0, 3);
    tick(2);
    rd(OFF_COUNT_LOW, 32'h7, 1'b0);
    wr(OFF_CONTROL, 32'h00);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_COUNT_LOW, 32'(8'h10 + m));
      wr(OFF_CAPT_CTRL, 32'(CAPT_FALL + m));
      wr(OFF_FLAGS, 32'h2);
      pm_u.pulse(1'b1, (m < 2) ? 0 : ((m == 2) ? 3 : 15));
      idle(8);
      check({32'h0, capture_event_flag}, 33'h0);
      pm_u.pulse(1'b1, 1);
      idle(8);
      check({32'h0, capture_event_flag}, 33'h1);
      rd(OFF_CAPT_LOW, 32'(8'h10 + m), 1'b0);
      check({32'h0, capture_event_flag}, 33'h1);
    end
    wr(OFF_COUNT_HIGH, 32'hAB);
    wr(OFF_CAPT_CTRL, 32'(CAPT_RISE));
    wr(OFF_FLAGS, 32'h2);
    pm_u.pulse(1'b1, 1);
    wr(OFF_COUNT_LOW, 32'h99);
    pm_u.pulse(1'b1, 1);
    idle(8);
    rd(OFF_CAPT_LOW, 32'h99, 1'b0);
    rd(OFF_CAPT_HIGH, 32'hAB, 1'b0);
    second_timer_value <= 16'($urandom);
    wr(OFF_SECOND_CTRL, 32'h1);
    idle(2);
    check({32'h0, capture_to_second}, 33'h1);
    pm_u.pulse(1'b1, 1);
    idle(8);
    rd(OFF_CAPT_LOW, {24'h0, second_timer_value[7:0]}, 1'b0);
    rd(OFF_CAPT_HIGH, {24'h0, second_timer_value[15:8]}, 1'b0);
    // a second reset in mid-run must return control, second-select and capture flag to their idle values
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    check({32'h0, capture_to_second}, 33'h0);
    check({32'h0, capture_event_flag}, 33'h0);
    rd(OFF_SECOND_CTRL, 32'h0, 1'b0);
    rd(OFF_CONTROL, 32'h0, 1'b0);
    idle(2);
    test_done();
  end
endmodule
`default_nettype wire
